// [include/single_shunt_pkg.sv]
// Constants and types shared by the single shunt current rebuild logic
package single_shunt_pkg;

  // Clock and PWM timing
  localparam int CLK_MHZ        = 100;
  localparam int PWM_PERIOD_NS  = 80000;
  localparam int HALF_CYCLES    = PWM_PERIOD_NS * CLK_MHZ / 2000;

  // Least time a gap state must last for a valid link sample
  localparam int MIN_GAP_NS     = 4000;
  localparam int MIN_GAP_CYCLES = (MIN_GAP_NS * CLK_MHZ + 999) / 1000;

  // Dead-band between upper and lower commutation of one leg
  localparam int DEAD_NS        = 200;
  localparam int DEAD_CYCLES    = (DEAD_NS * CLK_MHZ + 999) / 1000;

  // Compensating periods per measuring period is two to this power
  localparam int COMP_SHIFT     = 2;

  // Widths of the carrier counter and of current samples
  localparam int CNT_W          = 12;
  localparam int CUR_W          = 12;

  // Phase codes of a sample tag
  localparam logic [1:0] PH_A   = 2'h0;
  localparam logic [1:0] PH_B   = 2'h1;
  localparam logic [1:0] PH_C   = 2'h2;

  // Pattern values with no link current
  localparam logic [2:0] PAT_ALL_OFF = 3'h0;
  localparam logic [2:0] PAT_ALL_ON  = 3'h7;

  // Half of the symmetric carrier
  typedef enum logic [1:0] {
    HALF_RISE = 2'b01,
    HALF_FALL = 2'b10
  } half_t;

endpackage

// [rtl/dead_band_leg.sv]
// One inverter leg driver with complementary outputs and dead-band
`timescale 1ns/1ps
module dead_band_leg #(
  parameter int DEAD_CYC = single_shunt_pkg::DEAD_CYCLES
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic upperCmd,
  output logic      gateUpper,
  output logic      gateLower
);

  localparam logic [7:0] DEAD_LAST = 8'(DEAD_CYC - 1);

  logic       applied_q;   // Side currently allowed to conduct
  logic       applied_d;
  logic [7:0] dead_q;      // Cycles spent with both sides off
  logic [7:0] dead_d;
  logic       upper_d;
  logic       lower_d;

  // Next drive: both off while the command differs from the side in use
  always_comb begin
    applied_d = applied_q;
    dead_d    = '0;
    if (upperCmd != applied_q) begin
      upper_d = 1'b0;
      lower_d = 1'b0;
      if (dead_q >= DEAD_LAST) begin
        applied_d = upperCmd;
      end else begin
        dead_d = dead_q + 8'h01;
      end
    end else begin
      upper_d = applied_q;
      lower_d = ~applied_q;
    end
  end

  // Register drive state; reset leaves both transistors off
  always_ff @(posedge mclk) begin
    if (rst) begin
      applied_q <= 1'b0;
      dead_q    <= '0;
      gateUpper <= 1'b0;
      gateLower <= 1'b0;
    end else begin
      applied_q <= applied_d;
      dead_q    <= dead_d;
      gateUpper <= upper_d;
      gateLower <= lower_d;
    end
  end

endmodule

// [rtl/single_shunt_phase_current_rebuild.sv]
// Symmetric PWM, single shunt sampling and three phase current rebuild
`timescale 1ns/1ps
module single_shunt_phase_current_rebuild #(
  parameter int CNT_W      = single_shunt_pkg::CNT_W,
  parameter int CUR_W      = single_shunt_pkg::CUR_W,
  parameter int HALF_CYC   = single_shunt_pkg::HALF_CYCLES,
  parameter int MIN_CYC    = single_shunt_pkg::MIN_GAP_CYCLES,
  parameter int DEAD_CYC   = single_shunt_pkg::DEAD_CYCLES,
  parameter int COMP_SHIFT = single_shunt_pkg::COMP_SHIFT
) (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic [CNT_W-1:0]        onOffsetA,
  input  wire logic [CNT_W-1:0]        onOffsetB,
  input  wire logic [CNT_W-1:0]        onOffsetC,
  input  wire logic signed [CUR_W-1:0] adcData,
  input  wire logic                    adcDone,
  output logic                         phaseAUpperState,
  output logic                         phaseBUpperState,
  output logic                         phaseCUpperState,
  output logic [2:0]                   gateUpper,
  output logic [2:0]                   gateLower,
  output logic [2:0]                   patternValue,
  output logic                         measurePeriod,
  output logic                         gapStretched,
  output logic [CNT_W-1:0]             firstCommutationGap,
  output logic [CNT_W-1:0]             secondCommutationGap,
  output logic                         adcTrigger,
  output logic [1:0]                   sampleTag,
  output logic                         sampleNeg,
  output logic signed [CUR_W-1:0]      currentA,
  output logic signed [CUR_W-1:0]      currentB,
  output logic signed [CUR_W-1:0]      currentC,
  output logic                         currentsValid
);

  localparam int            PERIODS  = (1 << COMP_SHIFT) + 1;
  localparam logic [CNT_W-1:0] CNT_TOP = CNT_W'(HALF_CYC - 1);
  localparam logic [CNT_W:0]   MIN_W   = (CNT_W + 1)'(MIN_CYC);
  localparam logic [CNT_W:0]   HALF_W  = (CNT_W + 1)'(HALF_CYC);
  localparam logic [CNT_W-1:0] AGE_HIT = CNT_W'(MIN_CYC - 1);
  localparam logic [7:0]       IDX_END = 8'(PERIODS - 1);

  // Link current meaning of a pattern: {valid, negative, phase}
  function automatic logic [3:0] decodeLink(input logic [2:0] pat);
    logic [3:0] res;
    res = 4'h0;
    unique case (pat)
      3'h1: res = {2'b10, single_shunt_pkg::PH_A};
      3'h6: res = {2'b11, single_shunt_pkg::PH_A};
      3'h2: res = {2'b10, single_shunt_pkg::PH_B};
      3'h5: res = {2'b11, single_shunt_pkg::PH_B};
      3'h4: res = {2'b10, single_shunt_pkg::PH_C};
      3'h3: res = {2'b11, single_shunt_pkg::PH_C};
      single_shunt_pkg::PAT_ALL_OFF: res = 4'h0;
      single_shunt_pkg::PAT_ALL_ON:  res = 4'h0;
    endcase
    return res;
  endfunction

  // Carrier state
  single_shunt_pkg::half_t half_q;        // Rising or falling half
  single_shunt_pkg::half_t half_d;
  logic [CNT_W-1:0]        cnt_q;         // Carrier count
  logic [CNT_W-1:0]        cnt_d;
  logic                    periodStart;   // Last cycle of a period

  // Next carrier value: up to the top, then down to zero
  always_comb begin
    half_d      = half_q;
    cnt_d       = cnt_q;
    periodStart = 1'b0;
    unique case (half_q)
      single_shunt_pkg::HALF_RISE: begin
        if (cnt_q == CNT_TOP) begin
          half_d = single_shunt_pkg::HALF_FALL;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      single_shunt_pkg::HALF_FALL: begin
        if (cnt_q == '0) begin
          half_d      = single_shunt_pkg::HALF_RISE;
          periodStart = 1'b1;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        half_d = single_shunt_pkg::HALF_RISE;
        cnt_d  = '0;
      end
    endcase
  end

  // Register the carrier
  always_ff @(posedge mclk) begin
    if (rst) begin
      half_q <= single_shunt_pkg::HALF_RISE;
      cnt_q  <= '0;
    end else begin
      half_q <= half_d;
      cnt_q  <= cnt_d;
    end
  end

  // Offset shaping state
  logic [CNT_W-1:0] offIn [3];       // Requested switch-on counts
  logic [CNT_W-1:0] off_q [3];       // Counts used this period
  logic [CNT_W-1:0] offNext [3];
  logic [1:0]       minI;            // Phase that switches first
  logic [1:0]       maxI;            // Phase that switches last
  logic [1:0]       midI;
  logic [CNT_W:0]   vMin;
  logic [CNT_W:0]   vMid;
  logic [CNT_W:0]   vMax;
  logic [CNT_W:0]   gap1;            // Raw first gap
  logic [CNT_W:0]   gap2;            // Raw second gap
  logic [CNT_W:0]   newMid;
  logic [CNT_W:0]   newMax;
  logic [CNT_W:0]   cut1;            // Shortening of a compensating gap
  logic [CNT_W:0]   cut2;
  logic             stretch;
  logic             measureNext;     // Next period takes samples
  logic [7:0]       idx_q;           // Period index in control cycle
  logic [7:0]       idx_d;

  assign offIn[0] = onOffsetA;
  assign offIn[1] = onOffsetB;
  assign offIn[2] = onOffsetC;

  // Order the phases, then stretch or shorten the short gaps
  always_comb begin
    offNext = offIn;
    minI    = 2'd0;
    for (int j = 1; j < 3; j++) begin
      if (offIn[j] < offIn[minI]) begin
        minI = 2'(j);
      end
    end
    maxI = (minI == 2'd0) ? 2'd1 : 2'd0;
    for (int j = 0; j < 3; j++) begin
      if (2'(j) != minI && offIn[j] >= offIn[maxI]) begin
        maxI = 2'(j);
      end
    end
    midI = 2'd3 - minI - maxI;
    vMin = {1'b0, offIn[minI]};
    vMid = {1'b0, offIn[midI]};
    vMax = {1'b0, offIn[maxI]};
    gap1 = vMid - vMin;
    gap2 = vMax - vMid;
    idx_d = (idx_q >= IDX_END) ? 8'h00 : idx_q + 8'h01;
    measureNext = (idx_d == 8'h00);
    newMid  = vMid;
    newMax  = vMax;
    cut1    = '0;
    cut2    = '0;
    stretch = 1'b0;
    if (measureNext) begin
      if (gap1 < MIN_W) begin
        newMid  = vMin + MIN_W;
        stretch = 1'b1;
      end
      if (newMax < newMid + MIN_W) begin
        newMax  = newMid + MIN_W;
        stretch = 1'b1;
      end
    end else begin
      if (gap1 < MIN_W) begin
        cut1   = (MIN_W - gap1) >> COMP_SHIFT;
        cut1   = (cut1 > gap1) ? gap1 : cut1;
        newMid = vMid - cut1;
      end
      if (gap2 < MIN_W) begin
        cut2   = (MIN_W - gap2) >> COMP_SHIFT;
        cut2   = (cut2 > gap2) ? gap2 : cut2;
        newMax = vMax - cut2;
      end
    end
    // Beyond the half period a leg simply stays off
    newMid = (newMid > HALF_W) ? HALF_W : newMid;
    newMax = (newMax > HALF_W) ? HALF_W : newMax;
    offNext[minI] = vMin[CNT_W-1:0];
    offNext[midI] = newMid[CNT_W-1:0];
    offNext[maxI] = newMax[CNT_W-1:0];
  end

  // Take new offsets only at the period boundary
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int k = 0; k < 3; k++) begin
        off_q[k] <= CNT_W'(HALF_CYC);
      end
      idx_q                <= IDX_END;
      measurePeriod        <= 1'b0;
      gapStretched         <= 1'b0;
      firstCommutationGap  <= '0;
      secondCommutationGap <= '0;
    end else if (periodStart) begin
      off_q                <= offNext;
      idx_q                <= idx_d;
      measurePeriod        <= measureNext;
      gapStretched         <= stretch;
      firstCommutationGap  <= CNT_W'(newMid - vMin);
      secondCommutationGap <= CNT_W'(newMax - newMid);
    end
  end

  // Switch state and sampling state
  logic [2:0]       sw_q;            // Upper switch states, bit 0 is A
  logic [2:0]       sw_d;
  logic [CNT_W-1:0] age_q;           // Cycles since the pattern changed
  logic [CNT_W-1:0] age_d;
  logic [1:0]       taken_q;         // Samples triggered this period
  logic [1:0]       taken_d;
  logic [3:0]       dec;
  logic             trig_d;

  // Upper switch on while the carrier is at or above its offset, in both halves
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      sw_d[k] = (cnt_q >= off_q[k]);
    end
    age_d = (sw_d != sw_q) ? '0
          : (age_q == '1) ? age_q : age_q + 1'b1;
    dec     = decodeLink(sw_q);
    taken_d = periodStart ? 2'd0 : taken_q;
    trig_d  = measurePeriod && dec[3] && age_q == AGE_HIT &&
              half_q == single_shunt_pkg::HALF_RISE;
    trig_d  = trig_d && (taken_q < 2'd2) && !periodStart;
    if (trig_d) begin
      taken_d = taken_q + 2'd1;
    end
  end

  // Register switch state, pattern and trigger with its tag
  always_ff @(posedge mclk) begin
    if (rst) begin
      sw_q         <= '0;
      age_q        <= '0;
      taken_q      <= '0;
      patternValue <= '0;
      adcTrigger   <= 1'b0;
      sampleTag    <= '0;
      sampleNeg    <= 1'b0;
    end else begin
      sw_q         <= sw_d;
      age_q        <= age_d;
      taken_q      <= taken_d;
      patternValue <= sw_d;
      adcTrigger   <= trig_d;
      if (trig_d) begin
        sampleTag <= dec[1:0];
        sampleNeg <= dec[2];
      end
    end
  end

  assign phaseAUpperState = sw_q[0];
  assign phaseBUpperState = sw_q[1];
  assign phaseCUpperState = sw_q[2];

  // One driver per leg with complementary drive and dead-band
  for (genvar g = 0; g < 3; g++) begin : gLeg
    dead_band_leg #(
      .DEAD_CYC (DEAD_CYC)
    ) uLeg (
      .mclk      (mclk),
      .rst       (rst),
      .upperCmd  (sw_q[g]),
      .gateUpper (gateUpper[g]),
      .gateLower (gateLower[g])
    );
  end

  // Rebuild state
  logic signed [CUR_W-1:0] store_q [3];   // Signed phase samples
  logic signed [CUR_W-1:0] store_d [3];
  logic [2:0]              mask_q;        // Phases measured so far
  logic [2:0]              mask_d;
  logic signed [CUR_W:0]   sum;           // Sum of the two measured
  logic signed [CUR_W-1:0] cur_d [3];
  logic                    full;

  // Store each result with its sign; rebuild once two are held
  always_comb begin
    store_d = store_q;
    mask_d  = periodStart ? 3'b000 : mask_q;
    sum     = '0;
    full    = (mask_q == 3'b011) || (mask_q == 3'b101) ||
              (mask_q == 3'b110);
    for (int k = 0; k < 3; k++) begin
      if (mask_q[k]) begin
        sum = sum + (CUR_W + 1)'(store_q[k]);
      end
    end
    for (int k = 0; k < 3; k++) begin
      cur_d[k] = mask_q[k] ? store_q[k] : CUR_W'(-sum);
    end
    if (full) begin
      mask_d = 3'b000;
    end
    // A result arriving with a clear still counts
    if (adcDone) begin
      store_d[sampleTag] = sampleNeg ? CUR_W'(-adcData) : adcData;
      mask_d[sampleTag]  = 1'b1;
    end
  end

  // Register samples and rebuilt currents
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int k = 0; k < 3; k++) begin
        store_q[k] <= '0;
      end
      mask_q        <= '0;
      currentA      <= '0;
      currentB      <= '0;
      currentC      <= '0;
      currentsValid <= 1'b0;
    end else begin
      store_q       <= store_d;
      mask_q        <= mask_d;
      currentsValid <= full;
      if (full) begin
        currentA <= cur_d[0];
        currentB <= cur_d[1];
        currentC <= cur_d[2];
      end
    end
  end

endmodule

// [testbench/adc_link_model.sv]
// Inverter bridge and link converter model that answers conversions
`timescale 1ns/1ps
module adc_link_model #(
  parameter int CUR_W = single_shunt_pkg::CUR_W
) (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    adcTrigger,
  input  wire logic [2:0]              gateUpper,
  input  wire logic signed [CUR_W-1:0] loadA,
  input  wire logic signed [CUR_W-1:0] loadB,
  input  wire logic [3:0]              lat,
  output logic signed [CUR_W-1:0]      adcData,
  output logic                         adcDone
);
  logic signed [CUR_W-1:0] held;   // Link current caught at the start
  logic signed [CUR_W-1:0] loadC;  // Third phase current of the star
  logic [3:0]              cnt;    // Cycles left in the conversion

  assign loadC = -(loadA + loadB);

  // link path set by upper legs, lower legs complementary
  function automatic logic signed [CUR_W-1:0] linkCur(logic [2:0] g);
    case (g)
      3'h1: linkCur = loadA;
      3'h6: linkCur = -loadA;
      3'h2: linkCur = loadB;
      3'h5: linkCur = -loadB;
      3'h4: linkCur = loadC;
      3'h3: linkCur = -loadC;
      default: linkCur = '0;
    endcase
  endfunction

  // Idle values at time zero
  initial begin
    adcData = '0;
    adcDone = 1'b0;
  end

  // Conversion delay; the data line toggles while no result stands
  always @(posedge mclk) begin
    adcDone <= 1'b0;
    adcData <= ~adcData;
    if (rst) begin
      cnt <= 4'h0;
    end else if (adcTrigger) begin
      held <= linkCur(gateUpper);
      cnt  <= lat;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
        adcDone <= 1'b1;
        adcData <= held;
      end
    end
  end
endmodule

// [testbench/single_shunt_phase_current_rebuild_properties.sv]
// Port checker for the single shunt current rebuild logic
`timescale 1ns/1ps
module rebuild_checker #(
  parameter int CUR_W   = single_shunt_pkg::CUR_W,
  parameter int MIN_CYC = single_shunt_pkg::MIN_GAP_CYCLES
) (
  input wire logic                    mclk,
  input wire logic                    rst,
  input wire logic                    phaseAUpperState,
  input wire logic                    phaseBUpperState,
  input wire logic                    phaseCUpperState,
  input wire logic [2:0]              gateUpper,
  input wire logic [2:0]              gateLower,
  input wire logic [2:0]              patternValue,
  input wire logic                    measurePeriod,
  input wire logic                    adcTrigger,
  input wire logic [1:0]              sampleTag,
  input wire logic                    sampleNeg,
  input wire logic signed [CUR_W-1:0] currentA,
  input wire logic signed [CUR_W-1:0] currentB,
  input wire logic signed [CUR_W-1:0] currentC,
  input wire logic                    currentsValid
);
  logic [2:0] patPrev_q;  // Pattern one cycle back
  int         run_q;      // Age of the state one cycle back
  int         ageNow;     // Cycles since the pattern last changed
  int         trig_q;     // Triggers so far in this measuring period

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Expected sign and phase of a sample for a pattern
  function automatic logic [2:0] tagOf(logic [2:0] p);
    case (p)
      3'h1: tagOf = {1'b0, single_shunt_pkg::PH_A};
      3'h6: tagOf = {1'b1, single_shunt_pkg::PH_A};
      3'h2: tagOf = {1'b0, single_shunt_pkg::PH_B};
      3'h5: tagOf = {1'b1, single_shunt_pkg::PH_B};
      3'h4: tagOf = {1'b0, single_shunt_pkg::PH_C};
      3'h3: tagOf = {1'b1, single_shunt_pkg::PH_C};
      default: tagOf = 3'h7;
    endcase
  endfunction

  // Age of the present switch state
  always_comb ageNow = (patternValue == patPrev_q) ? run_q + 1 : 0;

  // Helper registers; the trigger count is cleared outside measuring periods
  always_ff @(posedge mclk) begin
    if (rst) begin
      patPrev_q <= 3'h0;
      run_q     <= 0;
      trig_q    <= 0;
    end else begin
      patPrev_q <= patternValue;
      run_q     <= ageNow;
      trig_q    <= measurePeriod ? trig_q + int'(adcTrigger) : 0;
    end
  end

  property p_no_overlap;
    (gateUpper & gateLower) == 3'h0;
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("upper and lower gate of one leg on together");
  // Dead-band of two cycles as set by the bench
  property p_dead_band;
    $fell(gateUpper[0]) |-> (!gateLower[0]) [*2];
  endproperty
  a_dead_band: assert property (p_dead_band)
    else $error("lower gate closed too soon after upper gate");
  property p_leg;
    (patternValue == $past(patternValue)) [*6]
      |-> gateUpper == patternValue && gateLower == ~patternValue;
  endproperty
  a_leg: assert property (p_leg)
    else $error("settled gates do not follow switch state");
  property p_pattern;
    patternValue == {phaseCUpperState, phaseBUpperState, phaseAUpperState};
  endproperty
  a_pattern: assert property (p_pattern)
    else $error("pattern value is not the weighted switch sum");
  // Within a half legs only open on the way up and close on the way down
  property p_order;
    patternValue != $past(patternValue) |->
      ((patternValue & $past(patternValue)) == $past(patternValue)) ||
      ((patternValue & $past(patternValue)) == patternValue);
  endproperty
  a_order: assert property (p_order)
    else $error("pattern step both opens and closes legs");
  property p_idle;
    adcTrigger |-> $past(patternValue) != 3'h0 && $past(patternValue) != 3'h7;
  endproperty
  a_idle: assert property (p_idle)
    else $error("conversion started with no link current");
  property p_tag;
    adcTrigger |-> {sampleNeg, sampleTag} == tagOf($past(patternValue));
  endproperty
  a_tag: assert property (p_tag)
    else $error("sample tag does not match switch state");
  property p_age;
    adcTrigger |-> $past(ageNow) == MIN_CYC - 1;
  endproperty
  a_age: assert property (p_age)
    else $error("conversion not started at minimum state age");
  property p_two;
    adcTrigger |-> trig_q < 2 && measurePeriod;
  endproperty
  a_two: assert property (p_two)
    else $error("extra conversion or conversion outside measuring");
  property p_sum;
    currentsValid |-> (currentA + currentB + currentC) == '0 ##1 !currentsValid;
  endproperty
  a_sum: assert property (p_sum)
    else $error("rebuilt currents do not sum to zero");

  c_trig: cover property (adcTrigger ##[1:40] adcTrigger);
  c_valid: cover property (currentsValid);
  c_meas: cover property ($rose(measurePeriod));
endmodule

bind single_shunt_phase_current_rebuild rebuild_checker #(
  .CUR_W(CUR_W), .MIN_CYC(MIN_CYC)
) rebuild_checker_inst (
  .mclk(mclk), .rst(rst), .phaseAUpperState(phaseAUpperState),
  .phaseBUpperState(phaseBUpperState), .phaseCUpperState(phaseCUpperState),
  .gateUpper(gateUpper), .gateLower(gateLower), .patternValue(patternValue),
  .measurePeriod(measurePeriod), .adcTrigger(adcTrigger),
  .sampleTag(sampleTag), .sampleNeg(sampleNeg), .currentA(currentA),
  .currentB(currentB), .currentC(currentC), .currentsValid(currentsValid)
);

// [testbench/single_shunt_phase_current_rebuild_tb.sv]
// Self-checking bench for the single shunt phase current rebuild
`timescale 1ns/1ps
`define CHECK(nm, ex, got) begin checkCount++; if ((got) !== (ex)) begin \
  miscompares++; $display("[FAIL] %s exp %0d got %0d", nm, ex, got); end end
module single_shunt_phase_current_rebuild_tb;
  localparam int HALF = 100;  // Short carrier half
  localparam int MIN  = 10;   // Short minimum gap
  localparam int CW   = single_shunt_pkg::CNT_W;
  localparam int IW   = single_shunt_pkg::CUR_W;
  logic                 mclk = 1'b0;                   // System clock
  logic                 rst  = 1'b1;                   // Sync reset
  logic [CW-1:0]        onA = '0, onB = '0, onC = '0;  // Turn-on counts
  logic signed [IW-1:0] loadA = '0, loadB = '0;        // Load currents
  logic [3:0]           lat = 4'h1;                    // Converter delay
  logic signed [IW-1:0] adcData, currentA, currentB, currentC;
  logic                 adcDone, adcTrigger, sampleNeg, measurePeriod;
  logic                 gapStretched, currentsValid, stA, stB, stC;
  logic [2:0]           gateUpper, gateLower, patternValue;
  logic [1:0]           sampleTag;
  logic [CW-1:0]        gap1, gap2;
  int                   miscompares = 0, checkCount = 0;

  single_shunt_phase_current_rebuild #(
    .HALF_CYC(HALF), .MIN_CYC(MIN), .DEAD_CYC(2)
  ) single_shunt_phase_current_rebuild_inst (
    .mclk(mclk), .rst(rst), .onOffsetA(onA), .onOffsetB(onB),
    .onOffsetC(onC), .adcData(adcData), .adcDone(adcDone),
    .phaseAUpperState(stA), .phaseBUpperState(stB), .phaseCUpperState(stC),
    .gateUpper(gateUpper), .gateLower(gateLower),
    .patternValue(patternValue), .measurePeriod(measurePeriod),
    .gapStretched(gapStretched), .firstCommutationGap(gap1),
    .secondCommutationGap(gap2), .adcTrigger(adcTrigger),
    .sampleTag(sampleTag), .sampleNeg(sampleNeg), .currentA(currentA),
    .currentB(currentB), .currentC(currentC), .currentsValid(currentsValid)
  );
  adc_link_model adc_link_model_inst (
    .mclk(mclk), .rst(rst), .adcTrigger(adcTrigger), .gateUpper(gateUpper),
    .loadA(loadA), .loadB(loadB), .lat(lat), .adcData(adcData),
    .adcDone(adcDone)
  );

  // Free running clock
  initial begin
    forever #5 mclk = ~mclk;
  end

  // Verdict and end of run
  task print_verdict;
    if (miscompares == 0 && checkCount > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Bounded wait for the measuring flag to reach a level
  task waitMeas(input logic lvl);
    int n;
    n = 0;
    while (measurePeriod !== lvl) begin
      @(posedge mclk);
      #1;
      n++;
      if (n > 12 * HALF) begin
        miscompares++;
        print_verdict();
      end
    end
  endtask

  // Gap left in a compensating period
  function automatic int compGap(int g);
    int cut;
    cut = (MIN - g) >> single_shunt_pkg::COMP_SHIFT;
    compGap = (g >= MIN) ? g : g - ((cut > g) ? g : cut);
  endfunction

  // One offset set through compensating and measuring periods
  task runCase(input int a, input int b, input int c, input bit off);
    int q[$];
    int g1, g2, m2, h2, n;
    logic sawValid;
    logic signed [IW-1:0] expC;
    @(posedge mclk);
    onA   <= CW'(a);
    onB   <= CW'(b);
    onC   <= CW'(c);
    loadA <= IW'($urandom_range(0, 1000) - 500);
    loadB <= IW'($urandom_range(0, 1000) - 500);
    lat   <= 4'($urandom_range(1, 5));
    waitMeas(1'b0);
    q = '{a, b, c};
    q.sort();
    g1 = q[1] - q[0];
    g2 = q[2] - q[1];
    if (!off && g1 >= MIN) begin
      `CHECK("comp gap1", g1, gap1)
      `CHECK("comp gap2", compGap(g2), gap2)
    end
    waitMeas(1'b1);
    m2 = (g1 < MIN) ? q[0] + MIN : q[1];
    h2 = (q[2] < m2 + MIN) ? m2 + MIN : q[2];
    if (!off) begin
      `CHECK("meas gap1", m2 - q[0], gap1)
      `CHECK("meas gap2", h2 - m2, gap2)
      `CHECK("stretched", g1 < MIN || q[2] < m2 + MIN, gapStretched)
    end
    sawValid = 1'b0;
    for (n = 0; n < 2 * HALF - 10 && !sawValid; n++) begin
      @(posedge mclk);
      #1;
      sawValid = (currentsValid === 1'b1);
    end
    expC = -(loadA + loadB);
    `CHECK("rebuilt", !off, sawValid)
    if (!off) begin
      `CHECK("currentA", loadA, currentA)
      `CHECK("currentB", loadB, currentB)
      `CHECK("currentC", expC, currentC)
    end
  endtask

  // Reset, corner cases, then random offsets
  initial begin
    void'($urandom(32'h90d5_1c3a));
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    waitMeas(1'b1);
    runCase(20, 50, 80, 0);        // Both gaps wide
    runCase(20, 25, 80, 0);        // First gap short
    runCase(60, 20, 63, 0);        // Second gap short, mixed order
    runCase(30, 30, 30, 0);        // All legs together
    runCase(40, 1, 40, 0);         // Second gap zero
    runCase(HALF, HALF, HALF, 1);  // All upper off
    runCase(0, 0, 0, 0);           // All on, stretched apart to sample
    repeat (16) begin
      runCase($urandom_range(1, 79), $urandom_range(1, 79),
              $urandom_range(1, 79), 0);
    end
    print_verdict();
  end
endmodule
